// [core/abspht_sync.v]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module abspht_sync #(
    parameter W = 1
) (
    input  wire         clk_sys,
    input  wire         srst,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    reg [W-1:0] out_ff;
    integer     i;

    // s1 feeds s2 only; the output moves once s2 and s3 agree
    always @(posedge clk_sys) begin
        if (srst) begin
            s1_ff  <= {W{1'b0}};
            s2_ff  <= {W{1'b0}};
            s3_ff  <= {W{1'b0}};
            out_ff <= {W{1'b0}};
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    out_ff[i] <= s3_ff[i];
                end
            end
        end
    end

    assign dout = out_ff;
endmodule

// [core/abspht_timer.v]
// millisecond timeout counter driven by a tick enable
`timescale 1ns/1ps
module abspht_timer #(
    parameter W = 16
) (
    input  wire         clk_sys,
    input  wire         srst,
    input  wire         tick,
    input  wire         clr,
    input  wire         run,
    input  wire [W-1:0] limit,
    output wire         expired
);
    reg [W-1:0] cnt_ff;
    reg [W-1:0] nxt_cnt;

    always @* begin
        nxt_cnt = cnt_ff;
        if (clr) begin
            nxt_cnt = {W{1'b0}};
        end else if (run && tick && (cnt_ff < limit)) begin
            nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            cnt_ff <= {W{1'b0}};
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // saturates, so expiry stays while run is high until cleared
    assign expired = run && (cnt_ff >= limit);
endmodule

// [core/abspht_top.v]
// absolute position handshake transfer, device side, with apb registers
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "abspht_regs.vh"

// Overview of operation
// (R1) transfer mode repurposes three flag outputs
// (R2) controller requests each portion via data_request
// (R3) low bit of pair on pair_low_bit
// (R4) high bit of pair on pair_high_bit
// (R5) home_set clears counter, stores home position
// (R6) pins fixed; outputs revert after transfer
// (R7) base circuit waits for transfer mode
// (R8) latch position on mode rise, load command
// (R9) drive_ready after mode drop; then ignore mode
// (R10) alarm refuses mode; warnings do not
// (R11) abort and warn on drop, clear, stop
// (R12) refuse mode while base on; 20ms off
// (R13) servo-on missing 1s raises warning
// (R14) determine position then raise pair_ready
// (R15) controller requests only after pair_ready
// (R16) request drives next pair, drops ready
// (R17) controller samples, then drops request
// (R18) ready again until data and checksum sent
// (R19) controller drops mode after 19th ready; the controller model drops it after the 20th, the one raised in ST_DONE
// (R20) checksum is 6-bit sum of pairs
// (R21) controller raises mode and servo-on together
// (R22) every servo-on comes with a transfer
// (R23) request rise timeout raises warning
// (R24) request fall timeout raises warning
// (R25) mode drop timeout after final ready
// (R26) mode rise clears transfer warning
// (R27) data bits stable until request falls
module abspht_top #(
    parameter TICK_CYC   = `ABSPHT_TICK_CYC,
    parameter XFER_TO_MS = `ABSPHT_T_XFER_TO_MS
) (
    input  wire        clk_sys,
    input  wire        srst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        xfer_mode_in,
    input  wire        data_request,
    input  wire        servo_on_cmd,
    input  wire        fault_clear,
    input  wire        emerg_stop,
    input  wire        home_set,
    input  wire        alarm_in,
    input  wire [31:0] cur_position,
    input  wire        norm_done,
    input  wire        norm_zero,
    input  wire        norm_tlim,
    output wire        position_done_flag,
    output wire        zero_speed_flag,
    output wire        torque_limit_flag,
    output wire        base_on,
    output wire        drive_ready,
    output wire        xfer_timeout_warning,
    output wire        servo_on_timeout_warning,
    output wire [31:0] pos_cmd,
    output wire        pos_cmd_load,
    output wire        counter_clear,
    output wire        home_store,
    output wire [31:0] home_data
);
    // ---------------------------------------------------------
    // states
    // ---------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_PREP = 3'd1;
    localparam [2:0] ST_RDY  = 3'd2;
    localparam [2:0] ST_SEND = 3'd3;
    localparam [2:0] ST_DONE = 3'd4;
    localparam [4:0] LAST    = `ABSPHT_GROUPS - 5'h01;
    localparam       DW      = `ABSPHT_POS_W + `ABSPHT_CSUM_W;
    localparam [31:0] CTRL_RST = `ABSPHT_CTRL_RST;

    // 6-bit sum of all 2-bit pairs of a word
    function [5:0] pair_sum;
        input [31:0] v;
        integer k;
        begin
            pair_sum = 6'h00;
            for (k = 0; k < 16; k = k + 1) begin
                pair_sum = pair_sum + {4'h0, v[2*k +: 2]};
            end
        end
    endfunction

    // ---------------------------------------------------------
    // pin synchronisers and edges
    // ---------------------------------------------------------
    wire [6:0] pin_s;
    abspht_sync #(.W(7)) u_sync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .din     ({alarm_in, home_set, emerg_stop, fault_clear,
                   servo_on_cmd, data_request, xfer_mode_in}),
        .dout    (pin_s)
    );
    wire xm_s  = pin_s[0];
    wire req_s = pin_s[1];
    wire son_s = pin_s[2];
    wire clr_s = pin_s[3];
    wire emg_s = pin_s[4];
    wire hs_s  = pin_s[5];
    wire alm_s = pin_s[6];

    reg xm_d_ff;
    reg son_d_ff;
    reg hs_d_ff;
    wire xm_rise  = xm_s & ~xm_d_ff;
    wire son_fall = ~son_s & son_d_ff;

    // ---------------------------------------------------------
    // millisecond tick
    // ---------------------------------------------------------
    reg [31:0] div_ff;
    wire       tick = (div_ff == TICK_CYC - 1);
    always @(posedge clk_sys) begin
        if (srst || tick) begin
            div_ff <= 32'h0000_0000;
        end else begin
            div_ff <= div_ff + 32'h0000_0001;
        end
    end

    // ---------------------------------------------------------
    // registers and state
    // ---------------------------------------------------------
    reg [2:0]    state_ff;
    reg [2:0]    nxt_state;
    reg [4:0]    grp_ff;
    reg [DW-1:0] shf_ff;
    reg [1:0]    pair_ff;
    reg [31:0]   latch_ff;
    reg [31:0]   home_ff;
    reg          home_pls_ff;
    reg          load_ff;
    reg          seen_ff;
    reg          rdy_ff;
    reg          xto_ff;
    reg          ctrl_det_ff;
    reg [31:0]   rdata_ff;
    wire         base_ok;
    wire         xfer_exp;
    wire         son_exp;

    wire active = (state_ff != ST_IDLE);
    // (R7) base only after mode seen
    wire base_w = seen_ff & son_s & ~alm_s & ~emg_s & ~active;
    // (R9) (R10) (R12) acceptance of mode
    wire accept = ctrl_det_ff & xm_rise & ~alm_s & ~rdy_ff
                  & ~base_w & base_ok;
    // (R11) abort causes during transfer
    wire abort  = ~xm_s | son_fall | clr_s | emg_s;

    // (R12) base must rest off before a new transfer
    abspht_timer #(.W(8)) u_boff (
        .clk_sys (clk_sys),
        .srst    (srst),
        .tick    (tick),
        .clr     (base_w),
        .run     (~base_w),
        .limit   (`ABSPHT_T_BASE_OFF_MS),
        .expired (base_ok)
    );

    // (R23) (R24) (R25) handshake watchdog, restarts per state
    abspht_timer #(.W(32)) u_xto (
        .clk_sys (clk_sys),
        .srst    (srst),
        .tick    (tick),
        .clr     (nxt_state != state_ff),
        .run     (state_ff == ST_RDY || state_ff == ST_SEND
                  || state_ff == ST_DONE),
        .limit   (XFER_TO_MS),
        .expired (xfer_exp)
    );

    // (R13) servo-on watchdog, warning only
    abspht_timer #(.W(11)) u_sto (
        .clk_sys (clk_sys),
        .srst    (srst),
        .tick    (tick),
        .clr     (accept | son_s),
        .run     (seen_ff & ~son_s),
        .limit   (`ABSPHT_T_SON_TO_MS),
        .expired (son_exp)
    );

    // ---------------------------------------------------------
    // transfer state machine
    // ---------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = ST_PREP;
                end
            end
            ST_PREP: begin
                // abort here too, or a short abort pulse is lost
                nxt_state = abort ? ST_IDLE : ST_RDY;
            end
            ST_RDY: begin
                if (abort) begin
                    nxt_state = ST_IDLE;
                end else if (req_s) begin
                    nxt_state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (abort) begin
                    nxt_state = ST_IDLE;
                end else if (!req_s) begin
                    nxt_state = (grp_ff == LAST) ? ST_DONE : ST_RDY;
                end
            end
            ST_DONE: begin
                if (!xm_s) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            state_ff    <= ST_IDLE;
            grp_ff      <= 5'd0;
            shf_ff      <= {DW{1'b0}};
            pair_ff     <= 2'b00;
            latch_ff    <= 32'h0000_0000;
            home_ff     <= 32'h0000_0000;
            home_pls_ff <= 1'b0;
            load_ff     <= 1'b0;
            seen_ff     <= 1'b0;
            rdy_ff      <= 1'b0;
            xto_ff      <= 1'b0;
            xm_d_ff     <= 1'b0;
            son_d_ff    <= 1'b0;
            hs_d_ff     <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            xm_d_ff     <= xm_s;
            son_d_ff    <= son_s;
            hs_d_ff     <= hs_s;
            load_ff     <= 1'b0;
            home_pls_ff <= 1'b0;
            // (R8) latch position, load as command
            if (accept) begin
                latch_ff <= cur_position;
                load_ff  <= 1'b1;
                seen_ff  <= 1'b1;
                grp_ff   <= 5'd0;
            end
            // mode may lead servo-on, so only a servo-on fall forgets it
            if (son_fall && !accept) begin
                seen_ff <= 1'b0;
            end
            // (R14) (R20) position and checksum staged
            if (state_ff == ST_PREP) begin
                shf_ff <= {pair_sum(latch_ff), latch_ff};
            end
            // (R16) (R27) next pair on request, held until next
            if (state_ff == ST_RDY && nxt_state == ST_SEND) begin
                pair_ff <= shf_ff[1:0];
                shf_ff  <= {2'b00, shf_ff[DW-1:2]};
            end
            // (R18) count pairs toward the final ready
            if (state_ff == ST_SEND && nxt_state == ST_RDY) begin
                grp_ff <= grp_ff + 5'd1;
            end
            // (R9) ready after mode drops at completion
            if (state_ff == ST_DONE && !xm_s) begin
                rdy_ff <= 1'b1;
            end else if (!son_s || alm_s) begin
                rdy_ff <= 1'b0;
            end
            // (R11) (R23) (R24) (R25) (R26) warning, set wins
            if ((active && state_ff != ST_DONE && abort)
                || xfer_exp) begin
                xto_ff <= 1'b1;
            end else if (xm_rise) begin
                xto_ff <= 1'b0;
            end
            // (R5) home position capture
            if (hs_s && !hs_d_ff) begin
                home_ff     <= cur_position;
                home_pls_ff <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------
    // apb slave, zero wait states
    // ---------------------------------------------------------
    wire        wr_en = psel & penable & pwrite;
    wire        hit   = (paddr == `ABSPHT_OFS_CTRL)
                      | (paddr == `ABSPHT_OFS_STATUS)
                      | (paddr == `ABSPHT_OFS_LATCH)
                      | (paddr == `ABSPHT_OFS_HOME);
    wire [31:0] status = {21'h00_0000, state_ff, 3'b000,
                          son_exp, xto_ff, rdy_ff, base_w, active};
    reg  [31:0] nxt_rdata;

    always @* begin
        case (paddr)
            `ABSPHT_OFS_CTRL:   nxt_rdata = {31'h0, ctrl_det_ff};
            `ABSPHT_OFS_STATUS: nxt_rdata = status;
            `ABSPHT_OFS_LATCH:  nxt_rdata = latch_ff;
            `ABSPHT_OFS_HOME:   nxt_rdata = home_ff;
            default:            nxt_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            ctrl_det_ff <= CTRL_RST[0];
            rdata_ff    <= 32'h0000_0000;
        end else begin
            if (wr_en && paddr == `ABSPHT_OFS_CTRL) begin
                ctrl_det_ff <= pwdata[`ABSPHT_CTRL_DETECT];
            end
            if (psel && !penable && !pwrite) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign prdata  = rdata_ff;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // ---------------------------------------------------------
    // outputs
    // ---------------------------------------------------------
    // (R1) (R6) outputs repurposed only during transfer mode
    wire repurp = ctrl_det_ff & xm_s & active;
    // (R3) low bit of pair
    assign position_done_flag = repurp ? pair_ff[0] : norm_done;
    // (R4) high bit of pair
    assign zero_speed_flag    = repurp ? pair_ff[1] : norm_zero;
    // (R14) (R16) (R18) ready while waiting for a request (ST_RDY) and in ST_DONE
    assign torque_limit_flag  = repurp ? (state_ff == ST_RDY ||
                                state_ff == ST_DONE) : norm_tlim;

    assign base_on                  = base_w;
    assign drive_ready              = rdy_ff;
    assign xfer_timeout_warning     = xto_ff;
    // (R13) self-clearing once servo-on seen
    assign servo_on_timeout_warning = son_exp;
    assign pos_cmd                  = latch_ff;
    assign pos_cmd_load             = load_ff;
    // (R5) clear counter and store home
    assign counter_clear            = home_pls_ff;
    assign home_store               = home_pls_ff;
    assign home_data                = home_ff;
endmodule

// [pkg/abspht_regs.vh]
// constants for the absolute position handshake transfer block
`ifndef ABSPHT_REGS_VH
`define ABSPHT_REGS_VH

// -------------------------------------------------------------
// register offsets (byte addresses)
// -------------------------------------------------------------
`define ABSPHT_OFS_CTRL    12'h000
`define ABSPHT_OFS_STATUS  12'h004
`define ABSPHT_OFS_LATCH   12'h008
`define ABSPHT_OFS_HOME    12'h00C

// -------------------------------------------------------------
// field positions and reset values
// -------------------------------------------------------------
`define ABSPHT_CTRL_DETECT   0
`define ABSPHT_CTRL_RST      32'h0000_0001
`define ABSPHT_ST_ACTIVE     0
`define ABSPHT_ST_BASE       1
`define ABSPHT_ST_RDY        2
`define ABSPHT_ST_XTO        3
`define ABSPHT_ST_STO        4
`define ABSPHT_ST_STATE      8

// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define ABSPHT_CLK_NS        5
`define ABSPHT_TICK_NS       1000000
`define ABSPHT_TICK_CYC      (`ABSPHT_TICK_NS / `ABSPHT_CLK_NS)
`define ABSPHT_T_XFER_TO_MS  5000
`define ABSPHT_T_SON_TO_MS   11'h3E8
`define ABSPHT_T_BASE_OFF_MS 8'h14

// -------------------------------------------------------------
// transfer layout
// -------------------------------------------------------------
`define ABSPHT_POS_W         32
`define ABSPHT_CSUM_W        6
`define ABSPHT_GROUPS        5'h13

`endif

// [sim/abspht_assertions.sv]
// checker on the pin side of the transfer block
`timescale 1ns/1ps
module abspht_chk (
    input wire        clk_sys,
    input wire        srst,
    input wire        xfer_mode_in,
    input wire        data_request,
    input wire        home_set,
    input wire [31:0] cur_position,
    input wire        norm_done,
    input wire        norm_zero,
    input wire        norm_tlim,
    input wire        position_done_flag,
    input wire        zero_speed_flag,
    input wire        torque_limit_flag,
    input wire        drive_ready,
    input wire        xfer_timeout_warning,
    input wire [31:0] pos_cmd,
    input wire        pos_cmd_load,
    input wire        counter_clear,
    input wire        home_store,
    input wire [31:0] home_data
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire nrm = position_done_flag == norm_done &&
               zero_speed_flag == norm_zero && torque_limit_flag == norm_tlim;
    wire tlf = torque_limit_flag;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_norm;
        !xfer_mode_in [*8] |-> nrm;
    endproperty
    a_norm: assert property (p_norm)
        else $error("flags not in normal role");
    property p_stab;
        xfer_mode_in && $past(xfer_mode_in) && data_request && !tlf &&
        !$past(tlf) |-> $stable(position_done_flag) && $stable(zero_speed_flag);
    endproperty
    a_stab: assert property (p_stab)
        else $error("pair bits moved");
    property p_drop;
        $rose(data_request) && tlf && xfer_mode_in |-> ##[2:8] !tlf;
    endproperty
    a_drop: assert property (p_drop)
        else $error("ready not dropped");
    property p_rearm;
        $fell(data_request) && xfer_mode_in && !tlf |-> ##[2:8] tlf;
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("ready not raised again");
    property p_rdy_rise;
        $rose(drive_ready) |-> !$past(xfer_mode_in, 3);
    endproperty
    a_rdy_rise: assert property (p_rdy_rise)
        else $error("ready output while mode on");
    property p_rdy_hold;
        drive_ready && $past(drive_ready) |-> tlf == norm_tlim;
    endproperty
    a_rdy_hold: assert property (p_rdy_hold)
        else $error("mode taken while ready");
    property p_wclr;
        $rose(xfer_mode_in) && xfer_timeout_warning
            |-> ##[1:10] !xfer_timeout_warning;
    endproperty
    a_wclr: assert property (p_wclr)
        else $error("warning kept after mode rise");
    property p_home;
        $rose(home_set) |-> ##[2:8] home_store;
    endproperty
    a_home: assert property (p_home)
        else $error("home store missing");
    property p_homep;
        home_store |-> counter_clear && home_data == cur_position
            ##1 !home_store;
    endproperty
    a_homep: assert property (p_homep)
        else $error("home store pulse wrong");
    property p_latch;
        pos_cmd_load |-> pos_cmd == cur_position ##1 !pos_cmd_load;
    endproperty
    a_latch: assert property (p_latch)
        else $error("position command wrong");
    c_done: cover property ($rose(drive_ready));
    c_warn: cover property ($rose(xfer_timeout_warning));
    c_home: cover property (home_store);
endmodule
bind abspht_top abspht_chk abspht_chk_inst (.*);

// [sim/abspht_plc_model.sv]
// controller model: reads the position over the pin handshake
`timescale 1ns/1ps
module abspht_plc_model (
    input  wire        clk_sys,
    input  wire        start,
    input  wire        son_off,
    input  wire [4:0]  stop_at,
    input  wire [7:0]  gap,
    input  wire        position_done_flag,
    input  wire        zero_speed_flag,
    input  wire        torque_limit_flag,
    output reg         xfer_mode_in,
    output reg         data_request,
    output reg         servo_on_cmd,
    output reg  [31:0] rx_pos,
    output reg  [5:0]  rx_csum,
    output reg  [5:0]  rx_sum,
    output reg         done,
    output reg         fail
);
    integer i;
    integer n;
    // bounded wait on pair_ready; a refused mode never raises it
    task wt(input logic v);
        begin
            n = 0;
            while (torque_limit_flag !== v && n < 200) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            if (n == 200)
                fail = 1'b1;
        end
    endtask
    initial begin
        {xfer_mode_in, data_request, servo_on_cmd} = 3'h0;
        {rx_pos, rx_csum, rx_sum, done, fail} = 0;
        forever begin
            @(posedge clk_sys);
            if (son_off)
                servo_on_cmd <= 1'b0;
            if (start) begin
                done = 1'b0;
                fail = 1'b0;
                rx_sum = 6'h00;
                xfer_mode_in <= 1'b1;
                servo_on_cmd <= 1'b1;
                @(posedge clk_sys);
                wt(1'b1);
                for (i = 0; i < 19 && !fail && i != stop_at; i++) begin
                    repeat (gap) @(posedge clk_sys);
                    data_request <= 1'b1;
                    @(posedge clk_sys);
                    wt(1'b0);
                    if (i < 16) begin
                        rx_pos[2*i +: 2] = {zero_speed_flag,
                                            position_done_flag};
                        rx_sum = rx_sum + {zero_speed_flag,
                                           position_done_flag};
                    end else
                        rx_csum[2*(i-16) +: 2] = {zero_speed_flag,
                                                  position_done_flag};
                    data_request <= 1'b0;
                    @(posedge clk_sys);
                    wt(1'b1);
                end
                xfer_mode_in <= 1'b0;
                done = 1'b1;
            end
        end
    end
endmodule

// [sim/abspht_top_tb.sv]
// testbench of the handshake transfer block
`timescale 1ns/1ps
`include "abspht_regs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module abspht_top_tb;
    logic        clk_sys, srst, psel, penable, pwrite, home_set, alarm_in;
    logic        fault_clear, emerg_stop, norm_done, norm_zero, norm_tlim;
    logic        start, son_off, e, w12;
    logic [11:0] paddr;
    logic [31:0] pwdata, cur_position, q;
    logic [4:0]  stop_at;
    logic [7:0]  gap;
    wire  [31:0] prdata, pos_cmd, home_data, rx_pos;
    wire  [5:0]  rx_csum, rx_sum;
    wire         pready, pslverr, xfer_mode_in, data_request, servo_on_cmd;
    wire         position_done_flag, zero_speed_flag, torque_limit_flag;
    wire         base_on, drive_ready, xfer_timeout_warning, done, fail;
    wire         servo_on_timeout_warning, pos_cmd_load, counter_clear;
    wire         home_store;
    int          err_total, num_checks, cyc, n;
    abspht_top #(.TICK_CYC(10), .XFER_TO_MS(5)) abspht_top_inst (.*);
    abspht_plc_model abspht_plc_model_inst (.*);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task end_sim;
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function [5:0] csum(input [31:0] p);
        csum = 6'h00;
        for (int k = 0; k < 16; k++)
            csum = csum + p[2*k +: 2];
    endfunction
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) err_total++;
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task run(input logic [31:0] p, input logic [7:0] g, input logic [4:0] s);
        {cur_position, gap, stop_at, start} <= {p, g, s, 1'b1};
        @(posedge clk_sys);
        start <= 1'b0;
        repeat (12) @(posedge clk_sys);
        w12 = xfer_timeout_warning;
        n = 0;
        while (done !== 1'b1 && n < 8000) begin
            @(posedge clk_sys);
            n++;
        end
        if (done !== 1'b1) err_total++;
        repeat (10) @(posedge clk_sys);
    endtask
    task t_servo;
        son_off <= 1'b1;
        @(posedge clk_sys);
        son_off <= 1'b0;
        repeat (220) @(posedge clk_sys);
        `CHK(base_on, 1'b0)
        `CHK(drive_ready, 1'b0)
    endtask
    task t_regs;
        apb(1'b0, `ABSPHT_OFS_CTRL, 32'h0000_0000);
        `CHK(q, `ABSPHT_CTRL_RST)
        apb(1'b1, 12'hFF0, 32'hFFFF_FFFF);
        `CHK(e, 1'b1)
        apb(1'b1, `ABSPHT_OFS_CTRL, 32'h0000_0000);
        repeat (220) @(posedge clk_sys);
        run(32'h0000_0055, 8'h02, 5'h1F);
        `CHK(fail, 1'b1)
        apb(1'b1, `ABSPHT_OFS_CTRL, 32'h0000_0001);
    endtask
    task t_good;
        run(32'hFFFF_FFF6, 8'h02, 5'h1F);
        `CHK(rx_pos, 32'hFFFF_FFF6)
        `CHK(rx_csum, 6'h2D)
        `CHK(rx_sum, rx_csum)
        `CHK(fail, 1'b0)
        `CHK(pos_cmd, 32'hFFFF_FFF6)
        `CHK(drive_ready, 1'b1)
        `CHK(xfer_timeout_warning, 1'b0)
        `CHK(servo_on_timeout_warning, 1'b0)
        `CHK(position_done_flag, norm_done)
        apb(1'b0, `ABSPHT_OFS_LATCH, 32'h0000_0000);
        `CHK(q, 32'hFFFF_FFF6)
        run(32'h0000_0001, 8'h02, 5'h1F);
        `CHK(fail, 1'b1)
        `CHK(drive_ready, 1'b1)
    endtask
    task t_fault;
        alarm_in <= 1'b1;
        run(32'h0000_0002, 8'h02, 5'h1F);
        `CHK(fail, 1'b1)
        alarm_in <= 1'b0;
        run(32'hA5A5_0F0F, 8'h02, 5'h05);
        `CHK(xfer_timeout_warning, 1'b1)
        `CHK(drive_ready, 1'b0)
    endtask
    task t_slow;
        run(32'h1234_5678, 8'h50, 5'h1F);
        `CHK(w12, 1'b0)
        `CHK(rx_pos, 32'h1234_5678)
        `CHK(rx_csum, csum(32'h1234_5678))
        `CHK(fail, 1'b0)
        `CHK(xfer_timeout_warning, 1'b1)
    endtask
    task t_estop;
        emerg_stop <= 1'b1;
        run(32'h0000_0003, 8'h02, 5'h1F);
        `CHK(xfer_timeout_warning, 1'b1)
        `CHK(fail, 1'b1)
        emerg_stop <= 1'b0;
    endtask
    task t_home;
        cur_position <= 32'h0001_2345;
        home_set <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (home_store !== 1'b1 && n < 20);
        `CHK(home_store, 1'b1)
        home_set <= 1'b0;
        apb(1'b0, `ABSPHT_OFS_HOME, 32'h0000_0000);
        `CHK(q, 32'h0001_2345)
    endtask
    // ----------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            end_sim;
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = 0;
        {home_set, alarm_in, fault_clear, emerg_stop} = 4'h0;
        {norm_done, norm_zero, norm_tlim, start, son_off} = 5'h10;
        {cur_position, stop_at, gap} = 0;
        srst = 1'b1;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        `CHK(torque_limit_flag, norm_tlim)
        `CHK(base_on, 1'b0)
        t_regs;
        t_good;
        t_servo;
        t_fault;
        t_servo;
        t_slow;
        t_servo;
        t_estop;
        t_home;
        end_sim;
    end
endmodule
